// ### sdatc_defines.svh
// register layout, reset values and timing codes of the sdram area timing block
// assumes inclusion by bare name from every design file that needs a constant
//
// Functional notes
// R1: bits 31..15 read zero, writes ignored
// R2: bits 14:13 precharge-done wait 0..3, reset 00
// R3: auto-precharge start to same-bank activate waits
// R4: precharge or all-bank close to activate waits
// R5: all-bank close to refresh waits precharge-done count
// R6: all-bank close to self-refresh waits too
// R7: bits 12 and 9 read zero
// R8: bits 11:10 activate-to-column wait, reset 01
// R9: bits 8:7 cas latency 1..3, reset 10
// R10: software never writes cas latency code 11
// R11: bits 6 and 5 read zero
// R12: bits 4:3 write-to-precharge wait, reset 00
// R13: precharge-start wait after write, both modes
// R14: waits counted in bus clocks, never shortened
`ifndef SDATC_DEFINES_SVH
`define SDATC_DEFINES_SVH

`define SDATC_ADDR_W 8
`define SDATC_DATA_W 32
`define SDATC_OFS_WAIT_CTRL 8'h00
`define SDATC_OFS_STATUS 8'h04

`define SDATC_TRP_HI 14
`define SDATC_TRP_LO 13
`define SDATC_TRCD_HI 11
`define SDATC_TRCD_LO 10
`define SDATC_CL_HI 8
`define SDATC_CL_LO 7
`define SDATC_WRITE_TO_PRECHARGE_WAIT_HI 4
`define SDATC_WRITE_TO_PRECHARGE_WAIT_LO 3

`define SDATC_TRP_RST 2'h0
`define SDATC_TRCD_RST 2'h1
`define SDATC_CL_RST 2'h2
`define SDATC_WRITE_TO_PRECHARGE_WAIT_RST 2'h0

`define SDATC_CNT_W 4
`define SDATC_BANKS 4
`define SDATC_CL_MAX 3

`endif

// ### sdatc_pkg.sv
// types shared by the sdram area timing block
// assumes sdatc_defines.svh is available on the include path
`include "sdatc_defines.svh"

package sdatc_pkg;

  typedef enum logic [3:0] {
    SDATC_NOP = 4'h0,
    SDATC_ROW_ACTIVATE = 4'h1,
    SDATC_READ = 4'h2,
    SDATC_READ_AP = 4'h3,
    SDATC_WRITE = 4'h4,
    SDATC_WRITE_AP = 4'h5,
    SDATC_PRECHARGE = 4'h6,
    SDATC_ALL_BANK_CLOSE = 4'h7,
    SDATC_REFRESH = 4'h8,
    SDATC_SELF_REFRESH = 4'h9
  } sdatc_cmd_t;

  typedef logic [`SDATC_CNT_W-1:0] sdatc_cnt_t;
  typedef logic [1:0] sdatc_bank_t;

endpackage : sdatc_pkg

// ### sdatc_props.sv
// assertions on the ports of the sdram area timing block
// assumes one clock domain and the register at offset 8'h00
`timescale 1ns/100ps
`default_nettype none
`include "sdatc_defines.svh"
module sdatc_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [31:0] regRdData,
  input wire logic cmdReqValid,
  input wire sdatc_pkg::sdatc_cmd_t cmdReqCode,
  input wire logic cmdReqReady,
  input wire logic sdramCmdValid,
  input wire sdatc_pkg::sdatc_cmd_t sdramCmd,
  input wire logic [1:0] casLatency,
  input wire logic readDataValid
);
  import sdatc_pkg::*;
  logic [1:0] trpQ;
  wire acc = cmdReqValid && cmdReqReady;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) trpQ <= 2'h0;
    else if (regWr && regAddr == 8'h00) trpQ <= regWrData[14:13];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  resv_high_a: assert property ($past(regRd) |-> regRdData[31:15] == 17'h0)
    else $error("reserved high bits set");
  resv_mid_a: assert property (regRdData[12] == 1'b0 && regRdData[9] == 1'b0)
    else $error("reserved bits 12 or 9 set");
  resv_low_a: assert property ($past(regRd) && $past(regAddr) == 8'h00 |->
    regRdData[6:5] == 2'h0) else $error("reserved bits 6:5 set");
  trp_readback_a: assert property ($past(regRd) && $past(regAddr) == 8'h00 |->
    regRdData[14:13] == trpQ) else $error("precharge wait readback");
  cas_follow_a: assert property (regWr && regAddr == 8'h00 |=>
    casLatency == $past(regWrData[8:7])) else $error("cas latency not updated");
  cmd_issue_a: assert property (acc |=> sdramCmdValid && sdramCmd == $past(cmdReqCode))
    else $error("accepted command not issued");
  no_issue_a: assert property (!acc |=> !sdramCmdValid)
    else $error("command issued without acceptance");
  read_lat_a: assert property (acc && cmdReqCode == SDATC_READ && casLatency == 2'h2 |->
    ##4 readDataValid) else $error("read data strobe late");
  close_gap_a: assert property (sdramCmdValid && sdramCmd == SDATC_ALL_BANK_CLOSE &&
    trpQ == 2'h3 |=> (!(sdramCmdValid && sdramCmd inside {SDATC_REFRESH, SDATC_SELF_REFRESH,
    SDATC_ROW_ACTIVATE}))[*3]) else $error("command too soon after bank close");
  cover property (acc && cmdReqCode == SDATC_REFRESH);
  cover property (acc && cmdReqCode == SDATC_SELF_REFRESH);
  cover property (readDataValid);
endmodule : sdatc_props
bind sdatc_top sdatc_props u_props (.clk(clk), .rst(rst), .regAddr(regAddr),
  .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
  .cmdReqValid(cmdReqValid), .cmdReqCode(cmdReqCode), .cmdReqReady(cmdReqReady),
  .sdramCmdValid(sdramCmdValid), .sdramCmd(sdramCmd), .casLatency(casLatency),
  .readDataValid(readDataValid));
`default_nettype wire

// ### sdatc_reg_file.sv
// wait control register and status readback of the sdram area timing block
// assumes a one-cycle strobe master; read data valid the cycle after the strobe
`timescale 1ns/100ps
`default_nettype none
`include "sdatc_defines.svh"

module sdatc_reg_file (
  input wire logic clk,
  input wire logic rst,
  input wire logic [`SDATC_ADDR_W-1:0] regAddr,
  input wire logic [`SDATC_DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [`SDATC_DATA_W-1:0] regRdData,
  input wire logic [`SDATC_BANKS-1:0] bankOpen,
  input wire logic [`SDATC_BANKS-1:0] bankActReady,
  input wire logic readPending,
  output logic [1:0] trpCode,
  output logic [1:0] trcdCode,
  output logic [1:0] clCode,
  output logic [1:0] trwlCode
);
  import sdatc_pkg::*;

  logic [1:0] trp_q;
  logic [1:0] trcd_q;
  logic [1:0] cl_q;
  logic [1:0] write_to_precharge_wait_q;
  logic [`SDATC_DATA_W-1:0] rdData_q;
  logic [`SDATC_DATA_W-1:0] waitWord;
  logic [`SDATC_DATA_W-1:0] statusWord;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trp_q <= `SDATC_TRP_RST; // [R2]
      trcd_q <= `SDATC_TRCD_RST; // [R8]
      cl_q <= `SDATC_CL_RST; // [R9]
      write_to_precharge_wait_q <= `SDATC_WRITE_TO_PRECHARGE_WAIT_RST; // [R12]
    end else if (regWr && (regAddr == `SDATC_OFS_WAIT_CTRL)) begin
      trp_q <= regWrData[`SDATC_TRP_HI:`SDATC_TRP_LO]; // [R2]
      trcd_q <= regWrData[`SDATC_TRCD_HI:`SDATC_TRCD_LO]; // [R8]
      cl_q <= regWrData[`SDATC_CL_HI:`SDATC_CL_LO]; // [R9]
      write_to_precharge_wait_q <= regWrData[`SDATC_WRITE_TO_PRECHARGE_WAIT_HI:`SDATC_WRITE_TO_PRECHARGE_WAIT_LO]; // [R12]
    end
  end

  always_comb begin
    // only the four fields are placed, every other bit stays zero
    waitWord = '0; // [R1] [R7] [R11]
    waitWord[`SDATC_TRP_HI:`SDATC_TRP_LO] = trp_q;
    waitWord[`SDATC_TRCD_HI:`SDATC_TRCD_LO] = trcd_q;
    waitWord[`SDATC_CL_HI:`SDATC_CL_LO] = cl_q;
    waitWord[`SDATC_WRITE_TO_PRECHARGE_WAIT_HI:`SDATC_WRITE_TO_PRECHARGE_WAIT_LO] = write_to_precharge_wait_q;
    statusWord = '0;
    statusWord[3:0] = bankOpen;
    statusWord[7:4] = bankActReady;
    statusWord[8] = readPending;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdData_q <= '0;
    end else if (regRd) begin
      unique case (regAddr)
        `SDATC_OFS_WAIT_CTRL: rdData_q <= waitWord;
        `SDATC_OFS_STATUS: rdData_q <= statusWord;
        default: rdData_q <= '0;
      endcase
    end else begin
      rdData_q <= '0;
    end
  end

  assign regRdData = rdData_q;
  assign trpCode = trp_q;
  assign trcdCode = trcd_q;
  assign clCode = cl_q;
  assign trwlCode = write_to_precharge_wait_q;

endmodule : sdatc_reg_file
`default_nettype wire

// ### sdatc_sdram_model.sv
// behavioural sdram bank state at the far side of the command pins
// assumes one-cycle command pulses; counts commands illegal for the bank state
`timescale 1ns/100ps
`default_nettype none
module sdatc_sdram_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic sdramCmdValid,
  input wire sdatc_pkg::sdatc_cmd_t sdramCmd,
  input wire sdatc_pkg::sdatc_bank_t sdramBank,
  output logic [7:0] faultCount
);
  import sdatc_pkg::*;
  logic [3:0] openQ;
  wire act = sdramCmd == SDATC_ROW_ACTIVATE;
  wire col = sdramCmd inside {SDATC_READ, SDATC_READ_AP, SDATC_WRITE, SDATC_WRITE_AP};
  wire rfs = sdramCmd inside {SDATC_REFRESH, SDATC_SELF_REFRESH};
  wire bad = (act && openQ[sdramBank]) || (col && !openQ[sdramBank]) || (rfs && openQ != 4'h0);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      openQ <= 4'h0;
      faultCount <= 8'h0;
    end else if (sdramCmdValid) begin
      if (bad) faultCount <= faultCount + 8'h1;
      if (act) openQ[sdramBank] <= 1'b1;
      if (sdramCmd inside {SDATC_PRECHARGE, SDATC_READ_AP, SDATC_WRITE_AP}) begin
        openQ[sdramBank] <= 1'b0;
      end
      if (sdramCmd == SDATC_ALL_BANK_CLOSE) openQ <= 4'h0;
    end
  end
endmodule : sdatc_sdram_model
`default_nettype wire

// ### sdatc_top.sv
// sdram area command timing gate: holds each requested command until its
// programmed minimum waits have run out, then issues it to the sdram pins stage
// assumes the requester holds a command stable until cmdReqReady accepts it
//
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "sdatc_defines.svh"

module sdatc_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic [`SDATC_ADDR_W-1:0] regAddr,
  input wire logic [`SDATC_DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [`SDATC_DATA_W-1:0] regRdData,
  input wire logic cmdReqValid,
  input wire sdatc_pkg::sdatc_cmd_t cmdReqCode,
  input wire sdatc_pkg::sdatc_bank_t cmdReqBank,
  output logic cmdReqReady,
  output logic sdramCmdValid,
  output sdatc_pkg::sdatc_cmd_t sdramCmd,
  output sdatc_pkg::sdatc_bank_t sdramBank,
  output logic [1:0] casLatency,
  output logic readDataValid
);
  import sdatc_pkg::*;

  function automatic logic isColumn(input sdatc_cmd_t c);
    isColumn = (c == SDATC_READ) || (c == SDATC_READ_AP) ||
               (c == SDATC_WRITE) || (c == SDATC_WRITE_AP);
  endfunction : isColumn

  function automatic logic isRead(input sdatc_cmd_t c);
    isRead = (c == SDATC_READ) || (c == SDATC_READ_AP);
  endfunction : isRead

  function automatic logic isWrite(input sdatc_cmd_t c);
    isWrite = (c == SDATC_WRITE) || (c == SDATC_WRITE_AP);
  endfunction : isWrite

  function automatic logic closesBank(input sdatc_cmd_t c);
    closesBank = (c == SDATC_PRECHARGE) || (c == SDATC_READ_AP) ||
                 (c == SDATC_WRITE_AP);
  endfunction : closesBank

  logic [1:0] trpCode;
  logic [1:0] trcdCode;
  logic [1:0] clCode;
  logic [1:0] trwlCode;
  sdatc_cnt_t trpCnt;
  sdatc_cnt_t trcdCnt;
  sdatc_cnt_t trwlCnt;
  sdatc_cnt_t apToActCnt;

  logic accept;
  logic [`SDATC_BANKS-1:0] bankHit;
  logic [`SDATC_BANKS-1:0] actReady;
  logic [`SDATC_BANKS-1:0] colReady;
  logic [`SDATC_BANKS-1:0] preReady;
  logic [`SDATC_BANKS-1:0] actLoad;
  logic [`SDATC_BANKS-1:0] colLoad;
  logic [`SDATC_BANKS-1:0] preLoad;
  sdatc_cnt_t actLoadVal [`SDATC_BANKS];
  logic [`SDATC_BANKS-1:0] bankOpen_q;
  logic allClosed;
  logic allActReady;
  logic allPreReady;
  logic gate;

  logic sdramCmdValid_q;
  sdatc_cmd_t sdramCmd_q;
  sdatc_bank_t sdramBank_q;
  logic [`SDATC_CL_MAX-1:0] casPipe_q;
  logic readDataValid_q;
  logic [1:0] clEff;

  sdatc_reg_file u_regs (
    .clk(clk),
    .rst(rst),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .regWr(regWr),
    .regRd(regRd),
    .regRdData(regRdData),
    .bankOpen(bankOpen_q),
    .bankActReady(actReady),
    .readPending(|casPipe_q),
    .trpCode(trpCode),
    .trcdCode(trcdCode),
    .clCode(clCode),
    .trwlCode(trwlCode)
  );

  // codes are plain cycle counts; widen once for the counters
  always_comb begin
    trpCnt = sdatc_cnt_t'(trpCode);
    trcdCnt = sdatc_cnt_t'(trcdCode);
    trwlCnt = sdatc_cnt_t'(trwlCode);
    // write with auto-precharge: the precharge only starts after the
    // write-to-precharge wait, one cycle later the precharge-done wait runs
    apToActCnt = sdatc_cnt_t'(trwlCnt + trpCnt + 4'h1); // [R3] [R13]
  end

  assign accept = cmdReqValid && cmdReqReady;

  genvar b;
  generate
    for (b = 0; b < `SDATC_BANKS; b++) begin : g_bank
      assign bankHit[b] = (cmdReqBank == sdatc_bank_t'(b));

      // activate gate: reloaded by every precharge kind touching the bank
      always_comb begin
        actLoad[b] = 1'b0;
        actLoadVal[b] = trpCnt;
        if (accept) begin
          if (cmdReqCode == SDATC_ALL_BANK_CLOSE) begin
            actLoad[b] = 1'b1; // [R4] [R5] [R6]
          end else if (bankHit[b] && (cmdReqCode == SDATC_PRECHARGE)) begin
            actLoad[b] = 1'b1; // [R4]
          end else if (bankHit[b] && (cmdReqCode == SDATC_READ_AP)) begin
            // read auto-precharge is taken to start with the command itself
            actLoad[b] = 1'b1; // [R3]
          end else if (bankHit[b] && (cmdReqCode == SDATC_WRITE_AP)) begin
            actLoad[b] = 1'b1; // [R3] [R13]
            actLoadVal[b] = apToActCnt;
          end
        end
      end

      assign colLoad[b] = accept && bankHit[b] &&
                          (cmdReqCode == SDATC_ROW_ACTIVATE); // [R8]
      assign preLoad[b] = accept && bankHit[b] && isWrite(cmdReqCode); // [R13]

      sdatc_wait_counter u_act (
        .clk(clk),
        .rst(rst),
        .load(actLoad[b]),
        .loadVal(actLoadVal[b]),
        .expired(actReady[b])
      );

      sdatc_wait_counter u_col (
        .clk(clk),
        .rst(rst),
        .load(colLoad[b]),
        .loadVal(trcdCnt),
        .expired(colReady[b])
      );

      sdatc_wait_counter u_pre (
        .clk(clk),
        .rst(rst),
        .load(preLoad[b]),
        .loadVal(trwlCnt),
        .expired(preReady[b])
      );

      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          bankOpen_q[b] <= 1'b0;
        end else if (accept) begin
          if (cmdReqCode == SDATC_ALL_BANK_CLOSE) begin
            bankOpen_q[b] <= 1'b0;
          end else if (bankHit[b] && (cmdReqCode == SDATC_ROW_ACTIVATE)) begin
            bankOpen_q[b] <= 1'b1;
          end else if (bankHit[b] && closesBank(cmdReqCode)) begin
            bankOpen_q[b] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  assign allClosed = ~|bankOpen_q;
  assign allActReady = &actReady;
  assign allPreReady = &preReady;

  // a command is held off until every wait it depends on has expired
  always_comb begin
    gate = 1'b0;
    unique case (cmdReqCode)
      SDATC_NOP: gate = 1'b1;
      SDATC_ROW_ACTIVATE: begin
        gate = actReady[cmdReqBank] && !bankOpen_q[cmdReqBank]; // [R3] [R4] [R14]
      end
      SDATC_PRECHARGE: gate = preReady[cmdReqBank]; // [R13] [R14]
      SDATC_ALL_BANK_CLOSE: gate = allPreReady; // [R13]
      SDATC_REFRESH: gate = allActReady && allClosed; // [R5] [R14]
      SDATC_SELF_REFRESH: gate = allActReady && allClosed; // [R6] [R14]
      default: begin
        // column commands land here; undefined codes are no column and stay refused
        gate = isColumn(cmdReqCode) && colReady[cmdReqBank] &&
               bankOpen_q[cmdReqBank]; // [R8] [R14]
      end
    endcase
  end

  assign cmdReqReady = gate;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sdramCmdValid_q <= 1'b0;
      sdramCmd_q <= SDATC_NOP;
      sdramBank_q <= '0;
    end else if (accept) begin
      sdramCmdValid_q <= 1'b1;
      sdramCmd_q <= cmdReqCode;
      sdramBank_q <= cmdReqBank;
    end else begin
      sdramCmdValid_q <= 1'b0;
      sdramCmd_q <= SDATC_NOP;
    end
  end

  // code 11 is prohibited; should it appear anyway the longest latency
  // is used so data are never sampled early
  assign clEff = (clCode == 2'h3) ? 2'h2 : clCode; // [R9] [R10]

  // cas pipe is clocked from the issue edge, so one stage per latency cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      casPipe_q <= '0;
    end else begin
      casPipe_q <= {casPipe_q[`SDATC_CL_MAX-2:0], accept && isRead(cmdReqCode)};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      readDataValid_q <= 1'b0;
    end else begin
      readDataValid_q <= casPipe_q[clEff]; // [R9]
    end
  end

  assign sdramCmdValid = sdramCmdValid_q;
  assign sdramCmd = sdramCmd_q;
  assign sdramBank = sdramBank_q;
  assign casLatency = clCode;
  assign readDataValid = readDataValid_q;

endmodule : sdatc_top
`default_nettype wire

// ### sdatc_wait_counter.sv
// one minimum-wait down counter
// assumes load values are wait cycles; expired means the dependent command may go
`timescale 1ns/100ps
`default_nettype none

module sdatc_wait_counter (
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input wire sdatc_pkg::sdatc_cnt_t loadVal,
  output logic expired
);
  import sdatc_pkg::*;

  sdatc_cnt_t cnt_q;
  sdatc_cnt_t dec;
  sdatc_cnt_t cnt_d;

  always_comb begin
    dec = (cnt_q == '0) ? '0 : sdatc_cnt_t'(cnt_q - 4'h1);
    // a later load never shortens a wait that is still running
    cnt_d = (load && (loadVal > dec)) ? loadVal : dec; // [R14]
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign expired = (cnt_q == '0);

endmodule : sdatc_wait_counter
`default_nettype wire

// ### tb.sv
// self-checking bench for the sdram area timing block
// assumes the checker binds itself and the sdram model sits on the command pins
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin samplesChecked++; if ((got) !== (exp)) begin nFail++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, got, exp); end end
module tb;
  import sdatc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic cmdReqValid = 1'b0;
  sdatc_cmd_t cmdReqCode = SDATC_NOP;
  sdatc_bank_t cmdReqBank = 2'h0;
  wire [31:0] regRdData;
  wire cmdReqReady, sdramCmdValid, readDataValid;
  wire sdatc_cmd_t sdramCmd;
  wire sdatc_bank_t sdramBank;
  wire [1:0] casLatency;
  wire [7:0] faultCount;
  int nFail = 0;
  int samplesChecked = 0;
  int cycles = 0;
  int n;
  always #4 clk = ~clk;
  sdatc_top uut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .cmdReqValid(cmdReqValid),
    .cmdReqCode(cmdReqCode), .cmdReqBank(cmdReqBank), .cmdReqReady(cmdReqReady),
    .sdramCmdValid(sdramCmdValid), .sdramCmd(sdramCmd), .sdramBank(sdramBank),
    .casLatency(casLatency), .readDataValid(readDataValid));
  sdatc_sdram_model mdl (.clk(clk), .rst(rst), .sdramCmdValid(sdramCmdValid),
    .sdramCmd(sdramCmd), .sdramBank(sdramBank), .faultCount(faultCount));
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    `CHK(regRdData, exp)
    // hand back on a rising edge so the next strobe starts right after it
    @(posedge clk);
  endtask : rd
  // valid stays high after acceptance so the next request can follow with no gap
  task automatic cmd(input sdatc_cmd_t c, input sdatc_bank_t b, output int w);
    w = 0;
    cmdReqCode <= c;
    cmdReqBank <= b;
    cmdReqValid <= 1'b1;
    @(negedge clk);
    while (cmdReqReady !== 1'b1 && w < 20) begin
      w++;
      @(negedge clk);
    end
    `CHK(cmdReqReady, 1'b1)
    @(posedge clk);
  endtask : cmd
  task automatic reset_values;
    rd(8'h00, 32'h0000_0500);
    wr(8'h08, 32'hFFFF_FFFF);
    rd(8'h08, 32'h0);
    // status: banks closed, every activate wait already expired
    rd(8'h04, 32'h0000_00F0);
    rd(8'h00, 32'h0000_0500);
  endtask : reset_values
  task automatic reserved_bits;
    wr(8'h00, 32'hFFFF_FE7F);
    rd(8'h00, 32'h0000_6C18);
  endtask : reserved_bits
  task automatic timing_sweep;
    logic [1:0] c;
    logic [31:0] w;
    for (int k = 0; k < 4; k++) begin
      c = (k == 3) ? 2'h0 : 2'(k);
      w = {17'h0, 2'(k), 1'b0, 2'(k), 1'b0, c, 2'b00, 2'(k), 3'b000};
      wr(8'h00, w);
      rd(8'h00, w);
      cmd(SDATC_ALL_BANK_CLOSE, 2'h0, n);
      cmd(SDATC_REFRESH, 2'h0, n);
      `CHK(n, k)
      cmd(SDATC_ALL_BANK_CLOSE, 2'h0, n);
      cmd(SDATC_SELF_REFRESH, 2'h0, n);
      `CHK(n, k)
      cmd(SDATC_ROW_ACTIVATE, 2'h1, n);
      cmd(SDATC_READ, 2'h1, n);
      `CHK(n, k)
      cmdReqValid <= 1'b0;
      n = 0;
      @(negedge clk);
      while (readDataValid !== 1'b1 && n < 10) begin
        n++;
        @(negedge clk);
      end
      `CHK(n, int'(c) + 1)
      @(posedge clk);
      cmd(SDATC_WRITE, 2'h1, n);
      cmd(SDATC_PRECHARGE, 2'h1, n);
      `CHK(n, k)
      cmd(SDATC_ROW_ACTIVATE, 2'h1, n);
      `CHK(n, k)
      cmd(SDATC_WRITE_AP, 2'h1, n);
      `CHK(n, k)
      cmd(SDATC_ROW_ACTIVATE, 2'h1, n);
      `CHK(n, 2 * k + 1)
      cmd(SDATC_READ_AP, 2'h1, n);
      cmd(SDATC_ROW_ACTIVATE, 2'h1, n);
      `CHK(n, k)
      cmdReqValid <= 1'b0;
      repeat (6) @(posedge clk);
    end
  endtask : timing_sweep
  task automatic stopTest;
    $display("checks %0d failures %0d", samplesChecked, nFail);
    if (nFail == 0 && samplesChecked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stopTest
  // generous ceiling: the whole sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      nFail++;
      stopTest;
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    reset_values;
    reserved_bits;
    timing_sweep;
    `CHK(faultCount, 8'h00)
    stopTest;
  end
endmodule : tb
`default_nettype wire
